// >>> rtl/eeprom_params.svh
// Timing, field and bus constants for the serial memory front end.
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH
`define CLK_MHZ        100
`define WRITE_TIME_US  5000
`define MEM_ADDR_W     17
`define MEM_WORDS      131072
`define ID_PAGE_BYTES  256
`define FIFO_DEPTH     4
`define SEL_TYPE_MEM   4'hA
`define SEL_TYPE_ID    4'hB
`define BIT_LAST       4'h7
`define BIT_ACK        4'h8
`define BIT_FIRST      4'h0
`define BIT_TENTH      4'h1
`define SEL_RW_BIT     0
`define SEL_A16_BIT    1
`define SEL_STRAP_LO   2
`define SEL_STRAP_HI   3
`define ID_LOCK_BIT    10
`define LOCK_DATA_BIT  1
`endif

// >>> rtl/eeprom_pkg.sv
// Types shared by the serial memory front end.
package eeprom_pkg;

    // Byte-level protocol states of the slave.
    typedef enum logic [2:0] {
        st_idle,
        st_sel,
        st_addr_hi,
        st_addr_lo,
        st_data,
        st_read,
        st_wait_stop,
        st_wcyc
    } state_t;

    // Target of a buffered write.
    typedef enum logic [1:0] {
        wk_mem,
        wk_id,
        wk_lock
    } wkind_t;

endpackage

// >>> rtl/i2c_eeprom_slave.sv
// Two-wire slave front end of a byte-wide nonvolatile memory.
`timescale 1ns/1ps
`include "eeprom_params.svh"

// ==========================================================
// Write buffer
// ==========================================================

// Small first-in first-out store; flush empties it at once.
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] buf_r [0:DEPTH-1];
    logic [PW:0]      wr_ptr_r;
    logic [PW:0]      rd_ptr_r;
    logic             do_push;
    logic             do_pop;
    logic             full;

    // Pointer arithmetic needs a power-of-two depth.
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
            $error("sync_fifo: DEPTH must be a power of two >= 2.");
        end
    endgenerate

    // Full when the wrap bits differ and the indices agree.
    assign full      = (wr_ptr_r[PW] != rd_ptr_r[PW]) &&
                       (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
    assign in_ready  = !full;
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign out_data  = buf_r[rd_ptr_r[PW-1:0]];
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    // Storage holds no reset; only the pointers matter.
    always_ff @(posedge clk) begin
        if (do_push) begin
            buf_r[wr_ptr_r[PW-1:0]] <= in_data;
        end
    end

    // Pointers; flush beats any push or pop in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else if (flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule

// ==========================================================
// Slave front end
// ==========================================================

module i2c_eeprom_slave
    import eeprom_pkg::*;
#(
    parameter int WRITE_CYC  = `WRITE_TIME_US * `CLK_MHZ,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    // Clock and power-on reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Two-wire bus; the master drives the clock.
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    // Straps and write protection.
    input  wire logic chip_select_strap_low,
    input  wire logic chip_select_strap_high,
    input  wire logic write_inhibit_input,
    // Status.
    output logic      standby,
    output logic      write_busy,
    output logic      id_locked
);
    localparam int CW = $clog2(WRITE_CYC + 1);
    localparam int FW = $bits(wkind_t) + `MEM_ADDR_W + 8;
    localparam logic [CW-1:0] WCYC_LOAD = CW'(WRITE_CYC - 1);

    // All buffered bytes must drain before the cycle ends.
    generate
        if (WRITE_CYC < FIFO_DEPTH) begin : g_bad
            $error("i2c_eeprom_slave: WRITE_CYC below FIFO_DEPTH.");
        end
    endgenerate

    // ======================================================
    // Storage
    // ======================================================

    logic [7:0] mem    [0:`MEM_WORDS-1];
    logic [7:0] id_mem [0:`ID_PAGE_BYTES-1];

    // ======================================================
    // Pin synchronisers and bus conditions
    // ======================================================

    logic [4:0] pin_raw;
    logic [4:0] meta_r;
    logic [4:0] sync_r;
    logic       scl_prev_r;
    logic       sda_prev_r;
    logic       scl_s;
    logic       sda_s;
    logic       strap_lo_s;
    logic       strap_hi_s;
    logic       inhibit_s;

    assign pin_raw = {write_inhibit_input, chip_select_strap_high,
                      chip_select_strap_low, sda_in, scl_in};

    // Two stages per pin; only the second stage is looked at.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 5'h03;
            sync_r <= 5'h03;
        end else begin
            meta_r <= pin_raw;
            sync_r <= meta_r;
        end
    end

    assign scl_s      = sync_r[0];
    assign sda_s      = sync_r[1];
    assign strap_lo_s = sync_r[2];
    assign strap_hi_s = sync_r[3];
    assign inhibit_s  = sync_r[4];

    // Previous synchronised levels for edge finding.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_prev_r <= scl_s;
            sda_prev_r <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // Start and stop need the clock high on both samples.
    assign scl_rise  = scl_s && !scl_prev_r;
    assign scl_fall  = !scl_s && scl_prev_r;
    assign start_det = scl_s && scl_prev_r &&
                       !sda_s && sda_prev_r;
    assign stop_det  = scl_s && scl_prev_r &&
                       sda_s && !sda_prev_r;

    // ======================================================
    // Byte decoding
    // ======================================================

    state_t              state_r;
    state_t              next_r;
    logic [3:0]          bit_cnt_r;
    logic [7:0]          shreg_r;
    logic [7:0]          tx_r;
    logic [`MEM_ADDR_W-1:0] addr_r;
    logic                id_sel_r;
    logic                id_lock_r;
    logic                ack_r;
    logic                pend_r;
    logic [CW-1:0]       wcnt_r;

    logic [7:0] rx_byte;
    logic       byte_done;
    logic       ack_rise;
    logic       sel_match;
    logic       data_ok;
    logic       byte_ack;
    state_t     byte_next;
    state_t     ack_next;
    wkind_t     push_kind;
    logic       push;
    logic       push_ready;
    logic       stop_write;
    logic       active;
    logic [7:0] rd_byte;

    // Select code check on type and strap bits.
    function automatic logic sel_ok(input logic [7:0] b,
                                    input logic hi,
                                    input logic lo);
        sel_ok = (b[7:4] == `SEL_TYPE_MEM ||
                  b[7:4] == `SEL_TYPE_ID) &&
                 b[`SEL_STRAP_HI] == hi &&
                 b[`SEL_STRAP_LO] == lo;
    endfunction

    assign active    = (state_r != st_idle) &&
                       (state_r != st_wait_stop) &&
                       (state_r != st_wcyc);
    assign rx_byte   = {shreg_r[6:0], sda_s};
    assign byte_done = active && scl_rise && bit_cnt_r == `BIT_LAST;
    assign ack_rise  = active && scl_rise && bit_cnt_r == `BIT_ACK;
    assign sel_match = sel_ok(rx_byte, strap_hi_s, strap_lo_s);

    // A locked page refuses data just as the inhibit pin does.
    assign data_ok = !inhibit_s && push_ready &&
                     !(id_sel_r && id_lock_r);

    // Ack for the byte now ending and the state after its ack.
    assign byte_ack =
        (state_r == st_sel)  ? sel_match :
        (state_r == st_data) ? data_ok :
        (state_r == st_read) ? 1'b0 : 1'b1;
    assign byte_next =
        (state_r == st_sel) ?
            (!sel_match ? st_idle :
             rx_byte[`SEL_RW_BIT] ? st_read : st_addr_hi) :
        (state_r == st_addr_hi) ? st_addr_lo :
        (state_r == st_addr_lo) ? st_data : state_r;
    // A read answered with no ack waits for the stop.
    assign ack_next = (state_r == st_read && sda_s) ?
                      st_wait_stop : next_r;

    assign push_kind = !id_sel_r ? wk_mem :
                       addr_r[`ID_LOCK_BIT] ? wk_lock : wk_id;
    assign push = byte_done && state_r == st_data && data_ok &&
                  (push_kind != wk_lock ||
                   rx_byte[`LOCK_DATA_BIT]);

    // Only a stop in the slot right after a data ack starts a
    // write; the stop's own clock rise has already counted one bit,
    // so the slot after the ack shows a count of one, not zero.
    assign stop_write = stop_det && state_r == st_data && pend_r &&
                        (bit_cnt_r == `BIT_FIRST ||
                         bit_cnt_r == `BIT_TENTH);
    assign rd_byte = id_sel_r ? id_mem[addr_r[7:0]] : mem[addr_r];

    // ======================================================
    // Write buffer and commit
    // ======================================================

    logic          f_valid;
    logic [FW-1:0] f_data;
    logic          f_pop;
    logic          f_flush;
    wkind_t        f_kind;
    logic [`MEM_ADDR_W-1:0] f_addr;
    logic [7:0]    f_byte;

    // Abandoned bytes are dropped on a new start or idle stop.
    assign f_flush = (state_r != st_wcyc) &&
                     (start_det || (stop_det && !stop_write));
    // Draining stalls outside the write cycle, so a page
    // longer than the buffer gets no ack for the extra bytes.
    assign f_pop   = (state_r == st_wcyc) && f_valid;
    assign f_kind  = wkind_t'(f_data[FW-1 -: $bits(wkind_t)]);
    assign f_addr  = f_data[8 +: `MEM_ADDR_W];
    assign f_byte  = f_data[7:0];

    sync_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_wbuf (
        .clk       (clk),
        .rst_n     (rst_n),
        .flush     (f_flush),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   ({push_kind, addr_r, rx_byte}),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    // Array writes happen only inside the write cycle.
    always_ff @(posedge clk) begin
        if (f_pop && !inhibit_s && f_kind == wk_mem) begin
            mem[f_addr] <= f_byte;
        end
        if (f_pop && !inhibit_s && f_kind == wk_id) begin
            id_mem[f_addr[7:0]] <= f_byte;
        end
    end

    // Lock flag; it survives only until the next reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_lock_r <= 1'b0;
        end else if (f_pop && !inhibit_s && f_kind == wk_lock) begin
            id_lock_r <= 1'b1;
        end
    end

    // ======================================================
    // Protocol state
    // ======================================================

    // Reset holds the bus logic idle and deaf.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= st_idle;
            next_r    <= st_idle;
            bit_cnt_r <= 4'h0;
            ack_r     <= 1'b0;
        end else begin
            case (state_r)
                st_wcyc: begin
                    if (wcnt_r == '0) begin
                        state_r <= st_idle;
                    end
                end
                default: begin
                    if (start_det) begin
                        state_r   <= st_sel;
                        bit_cnt_r <= 4'h0;
                    end else if (stop_det) begin
                        state_r <= stop_write ? st_wcyc
                                              : st_idle;
                    end else if (ack_rise) begin
                        bit_cnt_r <= 4'h0;
                        state_r   <= ack_next;
                    end else if (active && scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == `BIT_LAST) begin
                            ack_r  <= byte_ack;
                            next_r <= byte_next;
                        end
                    end
                end
            endcase
        end
    end

    // Write-cycle timer, loaded as the cycle begins.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wcnt_r <= '0;
        end else if (stop_write && state_r != st_wcyc) begin
            wcnt_r <= WCYC_LOAD;
        end else if (state_r == st_wcyc && wcnt_r != '0) begin
            wcnt_r <= wcnt_r - 1'b1;
        end
    end

    // Marks that this instruction has buffered a data byte.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
        end else if (push) begin
            pend_r <= 1'b1;
        end else if (start_det || stop_det) begin
            pend_r <= 1'b0;
        end
    end

    // Shift register, address counter and transmit byte.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg_r  <= 8'h00;
            tx_r     <= 8'h00;
            addr_r   <= '0;
            id_sel_r <= 1'b0;
        end else if (active && scl_rise) begin
            shreg_r <= rx_byte;
            if (byte_done) begin
                case (state_r)
                    st_sel: begin
                        if (sel_match) begin
                            id_sel_r  <= rx_byte[7:4] == `SEL_TYPE_ID;
                            addr_r[`MEM_ADDR_W-1] <= rx_byte[`SEL_A16_BIT];
                        end
                    end
                    st_addr_hi: addr_r[15:8] <= rx_byte;
                    st_addr_lo: addr_r[7:0]  <= rx_byte;
                    // Page writes roll over inside the page.
                    st_data: begin
                        if (data_ok) begin
                            addr_r[7:0] <= addr_r[7:0] + 8'h01;
                        end
                    end
                    st_read: addr_r <= addr_r + 1'b1;
                    default: ;
                endcase
            end
            if (ack_rise && ack_next == st_read) begin
                tx_r <= rd_byte;
            end else if (state_r == st_read) begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // ======================================================
    // Data line driver
    // ======================================================

    // Pulls low only on a falling clock so the master sees a
    // stable level at its rising edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_n <= 1'b1;
        end else if (!active || start_det || stop_det) begin
            sda_oe_n <= 1'b1;
        end else if (scl_fall) begin
            if (bit_cnt_r == `BIT_ACK) begin
                sda_oe_n <= !ack_r;
            end else if (state_r == st_read) begin
                sda_oe_n <= tx_r[7];
            end else begin
                sda_oe_n <= 1'b1;
            end
        end
    end

    // The pad only ever pulls low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // Status flags for the surrounding chip.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            standby    <= 1'b1;
            write_busy <= 1'b0;
            id_locked  <= 1'b0;
        end else begin
            standby    <= state_r == st_idle;
            write_busy <= state_r == st_wcyc;
            id_locked  <= id_lock_r;
        end
    end
endmodule

// >>> testbench/i2c_eeprom_slave_chk.sv
// Concurrent checks on the pins of the two-wire memory front end.
`timescale 1ns/1ps
module i2c_eeprom_slave_chk #(
    parameter int WRITE_CYC = 500000
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Bus pins.
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // Status.
    input wire logic standby,
    input wire logic write_busy
);
    logic       scl_q_r;
    logic       sda_q_r;
    logic [7:0] stop_age_r;
    int         busy_cnt_r;

    // Ages the last stop seen on the pins; saturates so it never wraps.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q_r    <= 1'b1;
            sda_q_r    <= 1'b1;
            stop_age_r <= 8'hFF;
            busy_cnt_r <= 0;
        end else begin
            scl_q_r    <= scl_in;
            sda_q_r    <= sda_in;
            busy_cnt_r <= write_busy ? busy_cnt_r + 1 : 0;
            if (scl_q_r && scl_in && !sda_q_r && sda_in) begin
                stop_age_r <= 8'h00;
            end else if (stop_age_r != 8'hFF) begin
                stop_age_r <= stop_age_r + 8'h01;
            end
        end
    end

    // ==========================================
    // Properties
    // ==========================================
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_OD_LOW: assert property (sda_out == 1'b0)
        else $error("data output value is not low");
    AST_RESET_IDLE: assert property ($rose(rst_n) |-> standby && sda_oe_n && !write_busy)
        else $error("not idle after reset release");
    AST_BUSY_QUIET: assert property (write_busy |-> sda_oe_n)
        else $error("data pulled during write cycle");
    AST_BUSY_LEN: assert property ($fell(write_busy) |-> busy_cnt_r inside {[WRITE_CYC-2:WRITE_CYC+2]})
        else $error("write cycle length wrong");
    AST_BUSY_STOP: assert property ($rose(write_busy) |-> stop_age_r <= 8'h0C)
        else $error("write cycle without a stop");
    AST_BUSY_AWAKE: assert property ($rose(write_busy) |-> !standby)
        else $error("standby at write cycle start");
    AST_IDLE_QUIET: assert property (standby |-> sda_oe_n)
        else $error("data pulled in standby");
    AST_PULL_HOLD: assert property ($fell(sda_oe_n) |-> !scl_in ##1 !sda_oe_n [*3])
        else $error("pull not at low clock or too short");
endmodule

bind i2c_eeprom_slave i2c_eeprom_slave_chk #(.WRITE_CYC(WRITE_CYC)) chk (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .standby(standby),
    .write_busy(write_busy));

// >>> testbench/i2c_master_model.sv
// Bus master model that drives the two-wire link.
`timescale 1ns/1ps
module i2c_master_model (
    // System clock and resolved data line.
    input  wire logic clk,
    input  wire logic sda_line,
    // Open-drain outputs; a one releases the line.
    output logic      scl,
    output logic      sda_drv
);
    // The clock stands high between frames; only this side makes it.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Waits n cycles, then steps just past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Start or repeated start.
    task automatic start();
        sda_drv = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b0;
        tick(2);
    endtask

    // Stop leaves both lines released.
    task automatic stop();
        sda_drv = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(4);
    endtask

    // One bit of 80 ns; sampled late in the high phase for margin.
    task automatic bit_io(input logic b, output logic s);
        sda_drv = b;
        tick(2);
        scl = 1'b1;
        tick(4);
        s = sda_line;
        scl = 1'b0;
        tick(2);
    endtask

    // Sends a byte MSB first; ack is high when the slave pulled low.
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // Reads a byte, then acks it or, when last, does not.
    task automatic recv(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule

// >>> testbench/i2c_eeprom_slave_test.sv
// Self-checking bench for the two-wire memory front end.
`timescale 1ns/1ps
module i2c_eeprom_slave_test;
    localparam int WCYC = 200;
    logic        clk, rst_n, scl, sda_drv, sda_line, sda_out, sda_oe_n;
    logic        strap_lo, strap_hi, inhibit, standby, write_busy;
    logic        id_locked, ack;
    logic [7:0]  rd;
    logic [16:0] addr;
    logic [7:0]  mem [int];
    int          failures, checks, seed;

    // The line has a pull-up; either party may pull it low.
    assign sda_line = sda_drv & (sda_oe_n | sda_out);

    i2c_eeprom_slave #(.WRITE_CYC(WCYC)) dut (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .chip_select_strap_low(strap_lo), .chip_select_strap_high(strap_hi),
        .write_inhibit_input(inhibit), .standby(standby),
        .write_busy(write_busy), .id_locked(id_locked));

    i2c_master_model m (
        .clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

    // 100 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Start, write select and both address bytes, each to be acked.
    task automatic head(input logic [16:0] a);
        m.start();
        m.send({4'hA, strap_hi, strap_lo, a[16], 1'b0}, ack);
        check(ack, 1);
        m.send(a[15:8], ack);
        check(ack, 1);
        m.send(a[7:0], ack);
        check(ack, 1);
    endtask

    // Bounded wait for the end of the write cycle.
    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < WCYC + 50) begin
            m.tick(1);
            n++;
        end
        check(write_busy, 0);
        if (write_busy !== 1'b0) end_sim();
    endtask

    // ==========================================
    // Scenarios
    // ==========================================
    initial begin
        seed = 32'h57257F26;
        failures = 0;
        checks = 0;
        rst_n = 1'b0;
        {strap_hi, strap_lo, inhibit} = 3'h0;
        repeat (6) @(posedge clk);
        #1;
        check({sda_oe_n, sda_out, standby, write_busy}, 4'hA);
        rst_n = 1'b1;
        m.tick(4);
        // Every strap setting against every select pair.
        for (int i = 0; i < 16; i++) begin
            {strap_hi, strap_lo} = i[1:0];
            m.start();
            m.send({4'hA, i[3:2], 2'b00}, ack);
            check(ack, i[3:2] == i[1:0]);
            m.stop();
            m.tick(2);
            check(standby, 1);
        end
        // Random straps from here on; the header follows them.
        {strap_hi, strap_lo} = 2'($random(seed));
        // Inhibited: header acked, data refused, no write cycle.
        inhibit = 1'b1;
        addr = 17'($random(seed));
        head(addr);
        m.send(8'h5A, ack);
        check(ack, 0);
        m.stop();
        m.tick(4);
        check(write_busy, 0);
        inhibit = 1'b0;
        // Five bytes across the page end; the fifth overflows the buffer.
        addr[7:0] = 8'hFE;
        head(addr);
        for (int k = 0; k < 5; k++) begin
            rd = 8'($random(seed));
            m.send(rd, ack);
            check(ack, k < 4);
            if (k < 4) mem[{addr[16:8], 8'(addr[7:0] + k)}] = rd;
        end
        m.stop();
        m.tick(4);
        check(write_busy, 1);
        m.start();
        m.send({4'hA, strap_hi, strap_lo, 2'b00}, ack);
        check(ack, 0);
        m.stop();
        wait_idle();
        m.tick(2);
        check(standby, 1);
        // Random reads at both ends of the rolled-over page.
        for (int j = 0; j < 2; j++) begin
            addr[7:0] = j[0] ? 8'hFE : 8'h00;
            head(addr);
            m.start();
            m.send({4'hA, strap_hi, strap_lo, addr[16], 1'b1}, ack);
            check(ack, 1);
            for (int k = 0; k < 2; k++) begin
                m.recv(k == 1, rd);
                check(rd, mem[addr + k]);
            end
            m.stop();
            m.tick(2);
            check(standby, 1);
        end
        // Lock the extra page; a second lock byte is then refused.
        for (int j = 0; j < 2; j++) begin
            if (j == 1) inhibit = 1'($random(seed));
            m.start();
            m.send({4'hB, strap_hi, strap_lo, 2'b00}, ack);
            check(ack, 1);
            m.send(8'h04, ack);
            check(ack, 1);
            m.send(8'h00, ack);
            m.send(8'h02, ack);
            check(ack, j == 0);
            m.stop();
            wait_idle();
            check(id_locked, 1);
        end
        inhibit = 1'b0;
        // A reset in mid-run leaves the device deaf.
        rst_n = 1'b0;
        m.start();
        m.send({4'hA, strap_hi, strap_lo, 2'b00}, ack);
        check(ack, 0);
        m.stop();
        rst_n = 1'b1;
        m.tick(4);
        // After release the device answers its select code again.
        m.start();
        m.send({4'hA, strap_hi, strap_lo, 2'b00}, ack);
        check(ack, 1);
        m.stop();
        m.tick(4);
        end_sim();
    end
endmodule
